// ---- src/sbh_consts.svh ----
// Purpose: Constants for the strap-selected bus hold pin block
// Assumes: Included by bare name from src/
// Notes:   Pin idle levels are the electrical levels seen on the board
`ifndef SBH_CONSTS_SVH
`define SBH_CONSTS_SVH

// ----------------------------------------------------------------------------
// Strap levels, pin levels and GPIO direction reset and width
// ----------------------------------------------------------------------------
`define SBH_STRAP_GPIO      1'h0
`define SBH_STRAP_MEMORY    1'h1
`define SBH_PIN_IDLE        1'h1
`define SBH_PIN_ACTIVE      1'h0
`define SBH_GPIO_DIR_RESET  3'h0
`define SBH_GPIO_BITS       3

`endif

// ---- src/sbh_pkg.sv ----
// Purpose: Types shared by the strap-selected bus hold pin block
// Assumes: Nothing beyond the constants header
// Notes:   State of each module is one packed struct
package sbh_pkg;

  // --------------------------------------------------------------------------
  // Enumerations
  // --------------------------------------------------------------------------
  typedef enum logic {
    SBH_FN_GPIO,
    SBH_FN_MEMORY
  } sbh_fn_t;

  typedef enum logic {
    SBH_OWN,
    SBH_HOLD
  } sbh_hold_state_t;

  // --------------------------------------------------------------------------
  // Module state
  // --------------------------------------------------------------------------
  typedef struct packed {
    sbh_hold_state_t state;
  } sbh_hold_regs_t;

  typedef struct packed {
    logic       locked;
    sbh_fn_t    fn;
    logic [2:0] gpio_dir;
    logic [2:0] gpio_in;
    logic [2:0] pin_out;
    logic [2:0] pin_oe;
    logic       bus_oe;
    logic       mem_clk;
  } sbh_mux_regs_t;

endpackage : sbh_pkg

// ---- src/sbh_hold_if.sv ----
// Purpose: Carries the hold handshake between pin mux and hold controller
// Assumes: Single clock domain
// Notes:   in_hold is a flop output of the controller
`timescale 1ns/100ps
interface sbh_hold_if;
  logic enable;
  logic hold_req;
  logic bus_idle;
  logic in_hold;

  modport ctrl (input enable, input hold_req, input bus_idle, output in_hold);
  modport mux  (output enable, output hold_req, output bus_idle, input in_hold);
endinterface : sbh_hold_if

// ---- src/sbh_hold_ctrl.sv ----
// Purpose: Bus hold state machine for the memory interface
// Assumes: Hold request already decoded to active high and synchronous
// Notes:   Hold is entered only between accesses so a cycle is never cut
`timescale 1ns/100ps
module sbh_hold_ctrl (
  input  wire logic  i_clk,
  input  wire logic  i_resetn,
  sbh_hold_if.ctrl   hold
);
  import sbh_pkg::*;

  sbh_hold_regs_t r;
  sbh_hold_regs_t next_r;

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    next_r = r;
    unique case (r.state)
      SBH_OWN: begin
        if (hold.enable && hold.hold_req && hold.bus_idle) begin
          next_r.state = SBH_HOLD;
        end
      end
      SBH_HOLD: begin
        // Release once the host drops its request, or the pins leave memory-interface use
        if (!hold.hold_req || !hold.enable) begin
          next_r.state = SBH_OWN;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r.state <= SBH_OWN;
    end else begin
      r <= next_r;
    end
  end

  assign hold.in_hold = (r.state == SBH_HOLD);

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  a_hold_needs_req: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $rose(hold.in_hold) |-> $past(hold.hold_req) && $past(hold.bus_idle) && $past(hold.enable))
    else $error("Hold entered without request or while bus busy");

  a_hold_release: assert property (@(posedge i_clk) disable iff (!i_resetn)
    hold.in_hold && !hold.hold_req |=> !hold.in_hold)
    else $error("Hold not released one cycle after request dropped");

endmodule : sbh_hold_ctrl

// ---- src/sbh_pin_mux.sv ----
// Purpose: Strap-selected pin mux for three parallel port pins and the
//          memory interface clock source
// Assumes: All pin inputs synchronous to i_clk; strap steady around release
// Notes:   Pin a carries sync output enable for space 3, pin b the bus hold
//          request, pin c the bus hold acknowledge when the strap is high
//
// Overview of operation
// - Strap low during reset picks GPIO, strap high picks memory-interface controls.
// - Pin function is frozen when reset is released.
// - In GPIO use every parallel bit leaves reset as an input.
// - Space 3 output enable is undriven in reset, then driven high.
// - Space 3 output enable is the synchronous memory read strobe for a FIFO.
// - Hold acknowledge is undriven in reset, then driven high.
// - Hold acknowledge only in hold state; memory bus outputs then released.
// - Clock select high routes the external memory clock to the interface.
// - Clock select low routes the internal system clock to the interface.
`timescale 1ns/100ps
`include "sbh_consts.svh"
module sbh_pin_mux #(
  parameter int unsigned GPIO_BITS = `SBH_GPIO_BITS
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_resetn,
  input  wire logic                 i_function_strap_pin,
  input  wire logic                 i_parallel_io_bit_a,
  output logic                      o_parallel_io_bit_a,
  output logic                      o_parallel_io_bit_a_oe,
  input  wire logic                 i_parallel_io_bit_b,
  output logic                      o_parallel_io_bit_b,
  output logic                      o_parallel_io_bit_b_oe,
  input  wire logic                 i_parallel_io_bit_c,
  output logic                      o_parallel_io_bit_c,
  output logic                      o_parallel_io_bit_c_oe,
  input  wire logic                 i_gpio_dir_we,
  input  wire logic [GPIO_BITS-1:0] i_gpio_dir,
  input  wire logic [GPIO_BITS-1:0] i_gpio_out,
  output logic [GPIO_BITS-1:0]      o_gpio_in,
  output sbh_pkg::sbh_fn_t          o_pin_function,
  output logic                      o_function_locked,
  input  wire logic                 i_chip_enable_space3_read,
  input  wire logic                 i_memory_bus_idle,
  output logic                      o_memory_bus_oe,
  input  wire logic                 i_memory_clock_source_select,
  input  wire logic                 i_external_memory_clock_in,
  input  wire logic                 i_internal_system_clock,
  output logic                      o_memory_clock
);
  import sbh_pkg::*;

  sbh_mux_regs_t r;
  sbh_mux_regs_t next_r;
  logic [2:0]    pin_in;
  logic          mem_mode;

  // --------------------------------------------------------------------------
  // Hold controller
  // --------------------------------------------------------------------------
  sbh_hold_if hold ();

  assign mem_mode      = r.locked && (r.fn == SBH_FN_MEMORY);
  assign hold.enable   = mem_mode;
  // Hold request pin is active low; a GPIO strap never lets it through
  assign hold.hold_req = mem_mode && (i_parallel_io_bit_b == `SBH_PIN_ACTIVE);
  // Acknowledge and bus release are registered, so they follow the grant by one cycle
  assign hold.bus_idle = i_memory_bus_idle;

  sbh_hold_ctrl u_hold (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .hold     (hold.ctrl)
  );

  // Bit order a, b, c matches the gpio vectors
  assign pin_in = {i_parallel_io_bit_c, i_parallel_io_bit_b, i_parallel_io_bit_a};

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    next_r = r;
    // Strap is caught on the first edge after release; the strap must be held
    // through that edge, a limitation accepted to keep async reset constant
    if (!r.locked) begin
      next_r.locked = 1'h1;
      next_r.fn     = (i_function_strap_pin == `SBH_STRAP_MEMORY) ? SBH_FN_MEMORY : SBH_FN_GPIO;
    end
    if (r.locked && i_gpio_dir_we) begin
      next_r.gpio_dir = i_gpio_dir[2:0];
    end
    next_r.gpio_in = pin_in;
    if (!r.locked) begin
      next_r.pin_oe  = 3'h0;
      next_r.pin_out = {3{`SBH_PIN_IDLE}};
      next_r.bus_oe  = 1'h0;
    end else if (r.fn == SBH_FN_MEMORY) begin
      next_r.pin_out[0] = i_chip_enable_space3_read ? `SBH_PIN_ACTIVE : `SBH_PIN_IDLE;
      next_r.pin_oe[0]  = 1'h1;
      // Pin b stays an input here: it carries the host's hold request
      next_r.pin_out[1] = `SBH_PIN_IDLE;
      next_r.pin_oe[1]  = 1'h0;
      next_r.pin_out[2] = hold.in_hold ? `SBH_PIN_ACTIVE : `SBH_PIN_IDLE;
      next_r.pin_oe[2]  = 1'h1;
      next_r.bus_oe     = !hold.in_hold;
    end else begin
      // Enables come from the direction register, so a fresh write shows one cycle later
      next_r.pin_out = i_gpio_out[2:0];
      next_r.pin_oe  = r.gpio_dir;
      next_r.bus_oe  = 1'h1;
    end
    // Clock levels are resampled, so the routed clock is at most half i_clk
    next_r.mem_clk = i_memory_clock_source_select ? i_external_memory_clock_in
                                                  : i_internal_system_clock;
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r.locked   <= 1'h0;
      r.fn       <= SBH_FN_GPIO;
      r.gpio_dir <= `SBH_GPIO_DIR_RESET;
      r.gpio_in  <= 3'h0;
      r.pin_out  <= {3{`SBH_PIN_IDLE}};
      r.pin_oe   <= 3'h0;
      r.bus_oe   <= 1'h0;
      r.mem_clk  <= 1'h0;
    end else begin
      r <= next_r;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign o_parallel_io_bit_a    = r.pin_out[0];
  assign o_parallel_io_bit_a_oe = r.pin_oe[0];
  assign o_parallel_io_bit_b    = r.pin_out[1];
  assign o_parallel_io_bit_b_oe = r.pin_oe[1];
  assign o_parallel_io_bit_c    = r.pin_out[2];
  assign o_parallel_io_bit_c_oe = r.pin_oe[2];
  assign o_gpio_in              = r.gpio_in;
  assign o_pin_function         = r.fn;
  assign o_function_locked      = r.locked;
  assign o_memory_bus_oe        = r.bus_oe;
  assign o_memory_clock         = r.mem_clk;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  a_strap_capture: assert property (
    $rose(r.locked) |-> r.fn == ($past(i_function_strap_pin) ? SBH_FN_MEMORY : SBH_FN_GPIO))
    else $error("Pin function does not match strap");

  a_function_frozen: assert property (
    r.locked |=> r.locked && $stable(r.fn))
    else $error("Pin function changed after release");

  a_pins_undriven: assert property (
    !r.locked |-> !o_parallel_io_bit_a_oe && !o_parallel_io_bit_c_oe && !o_memory_bus_oe)
    else $error("Pins or memory bus driven before the function is fixed");

  a_dir_reset: assert property (
    $rose(r.locked) |-> r.gpio_dir == `SBH_GPIO_DIR_RESET)
    else $error("Parallel bit direction not input after reset");

  a_gpio_inputs: assert property (
    $rose(r.locked) && r.fn == SBH_FN_GPIO |=> o_parallel_io_bit_a_oe == 1'h0
      && o_parallel_io_bit_b_oe == 1'h0 && o_parallel_io_bit_c_oe == 1'h0)
    else $error("GPIO bit driven right after reset");

  a_soe_driven: assert property (
    $rose(r.locked) && r.fn == SBH_FN_MEMORY && !i_chip_enable_space3_read
      |=> o_parallel_io_bit_a_oe && o_parallel_io_bit_a == `SBH_PIN_IDLE)
    else $error("Space 3 output enable not driven high after reset");

  a_soe_strobe: assert property (
    mem_mode ##1 mem_mode |-> o_parallel_io_bit_a == !$past(i_chip_enable_space3_read))
    else $error("Space 3 output enable does not follow read");

  a_holda_driven: assert property (
    $rose(r.locked) && r.fn == SBH_FN_MEMORY
      |=> o_parallel_io_bit_c_oe && o_parallel_io_bit_c == `SBH_PIN_IDLE && !o_parallel_io_bit_b_oe)
    else $error("Hold acknowledge pin not driven high after reset");

  // Acknowledge and bus release must both track the controller's state one edge late
  a_holda_state: assert property (
    mem_mode && $past(mem_mode) |-> (o_parallel_io_bit_c == `SBH_PIN_ACTIVE) == $past(hold.in_hold))
    else $error("Hold acknowledge does not follow hold state");

  a_holda_bus_off: assert property (
    mem_mode && $past(mem_mode) |-> o_parallel_io_bit_c == o_memory_bus_oe)
    else $error("Hold acknowledge and bus release disagree");

  a_hold_req_input: assert property (
    mem_mode |=> !o_parallel_io_bit_b_oe)
    else $error("Hold request pin driven in memory-interface use");

  a_gpio_bus_on: assert property (
    r.locked && r.fn == SBH_FN_GPIO |=> o_memory_bus_oe)
    else $error("Memory bus released although hold is unavailable");

  // Sampled reset keeps the release edge out, where the clock flop still holds its reset level
  a_clk_external: assert property (
    i_resetn && i_memory_clock_source_select |=> o_memory_clock == $past(i_external_memory_clock_in))
    else $error("External memory clock not routed");

  a_clk_internal: assert property (
    i_resetn && !i_memory_clock_source_select |=> o_memory_clock == $past(i_internal_system_clock))
    else $error("Internal system clock not routed");

  // Covers show both straps, a held then granted hold, and a FIFO read
  c_memory_mode: cover property ($rose(r.locked) && r.fn == SBH_FN_MEMORY);
  c_gpio_mode:   cover property ($rose(r.locked) && r.fn == SBH_FN_GPIO);
  c_hold_cycle:  cover property ($rose(hold.in_hold) ##[1:20] $fell(hold.in_hold));
  c_fifo_read:   cover property (mem_mode && o_parallel_io_bit_a == `SBH_PIN_ACTIVE);
  c_hold_wait:   cover property (hold.hold_req && !hold.bus_idle ##1 hold.hold_req && hold.bus_idle);

endmodule : sbh_pin_mux

// ---- verification/sbh_host_model.sv ----
// Purpose: External host that borrows the memory bus through hold request
// Assumes: Acknowledge pin level is resolved by the bench
// Notes:   Drives the bus only after acknowledge, then i_len more cycles
`timescale 1ns/100ps
module sbh_host_model (
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_start,
  input  wire logic [3:0] i_len,
  input  wire logic       i_ack_n,
  output logic            o_req_n,
  output logic            o_drive
);
  logic [3:0] cnt;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_req_n <= 1'h1;
      o_drive <= 1'h0;
      cnt     <= 4'h0;
    end else if (o_req_n) begin
      if (i_start) begin
        o_req_n <= 1'h0;
        cnt     <= i_len;
      end
    end else if (!i_ack_n) begin
      o_drive <= 1'h1;
      cnt     <= cnt - 4'h1;
      if (cnt == 4'h0) begin
        o_req_n <= 1'h1;
        o_drive <= 1'h0;
      end
    end
  end
endmodule : sbh_host_model

// ---- verification/sbh_pin_mux_tb.sv ----
// Purpose: Self-checking bench for the strap-selected pin mux
// Assumes: Pins resolved here; the host model borrows the bus
// Notes:   Expectations use input samples of the previous edge
`timescale 1ns/100ps
module sbh_pin_mux_tb;
  import sbh_pkg::*;
  logic       i_clk, i_resetn, strap, dir_we, rd, idle, sel, ext, isc, start, live, mode;
  logic       p_rd, p_mclk, bus_oe, mclk, locked, req_n, drive;
  logic [2:0] dir, gout, drv, gin, pin_o, pin_oe, exp_dir, exp_oe, p_gout, p_pin;
  logic [3:0] len;
  sbh_fn_t    fn;
  wire        pa, pb, pc;
  int         miscompares, compares, seed;

  // Undriven pins take a random level, except pin b in memory use, which takes the host's request, so a stale value cannot pass
  assign pa = pin_oe[0] ? pin_o[0] : drv[0];
  assign pb = pin_oe[1] ? pin_o[1] : (mode ? req_n : drv[1]);
  assign pc = pin_oe[2] ? pin_o[2] : drv[2];

  sbh_pin_mux dut_u (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_function_strap_pin(strap),
    .i_parallel_io_bit_a(pa), .o_parallel_io_bit_a(pin_o[0]), .o_parallel_io_bit_a_oe(pin_oe[0]),
    .i_parallel_io_bit_b(pb), .o_parallel_io_bit_b(pin_o[1]), .o_parallel_io_bit_b_oe(pin_oe[1]),
    .i_parallel_io_bit_c(pc), .o_parallel_io_bit_c(pin_o[2]), .o_parallel_io_bit_c_oe(pin_oe[2]),
    .i_gpio_dir_we(dir_we), .i_gpio_dir(dir), .i_gpio_out(gout), .o_gpio_in(gin),
    .o_pin_function(fn), .o_function_locked(locked), .i_chip_enable_space3_read(rd),
    .i_memory_bus_idle(idle), .o_memory_bus_oe(bus_oe), .i_memory_clock_source_select(sel),
    .i_external_memory_clock_in(ext), .i_internal_system_clock(isc), .o_memory_clock(mclk));

  sbh_host_model host_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_start(start), .i_len(len),
    .i_ack_n(pc), .o_req_n(req_n), .o_drive(drive));

  initial begin
    i_clk = 1'h0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_vec(input logic [2:0] got, input logic [2:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %b expected %b", $time, got, exp);
    end
  endtask : chk_vec

  function automatic logic exp_mem_clk(input logic s, input logic e, input logic i);
    return s ? e : i;
  endfunction : exp_mem_clk

  // Space 3 output enable is active low while a read is under way
  function automatic logic exp_strobe(input logic rd_now);
    return rd_now ? 1'h0 : 1'h1;
  endfunction : exp_strobe

  task automatic summarize();
    if (miscompares == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------------------
  // Per-cycle checks
  // ----------------------------------------------------------------------------
  always @(posedge i_clk) begin
    exp_oe = exp_dir;
    if (!i_resetn) begin
      exp_dir = 3'h0;
    end else if (dir_we && locked) begin
      exp_dir = dir;
    end
    p_gout = gout;
    p_rd   = rd;
    p_mclk = exp_mem_clk(sel, ext, isc);
    p_pin  = {pc, pb, pa};
  end

  always @(negedge i_clk) begin
    if (live) begin
      chk_bit(mclk, p_mclk);
      chk_vec(gin, p_pin);
      if (mode) begin
        chk_vec(pin_oe, 3'h5);
        chk_bit(pin_o[0], exp_strobe(p_rd));
        chk_bit(pin_o[2], bus_oe);
        chk_bit(bus_oe & drive, 1'h0);
      end else begin
        chk_vec(pin_oe, exp_oe);
        chk_vec(pin_o & exp_oe, p_gout & exp_oe);
        chk_bit(bus_oe, 1'h1);
      end
    end
  end

  task automatic do_reset(input logic s);
    i_resetn <= 1'h0;
    live     <= 1'h0;
    mode     <= s;
    strap    <= s;
    repeat (12) @(posedge i_clk);
    #1 chk_vec(pin_oe, 3'h0);
    chk_bit(bus_oe, 1'h0);
    @(posedge i_clk) i_resetn <= 1'h1;
    @(posedge i_clk) strap <= ~s;
    #1 chk_bit(locked, 1'h1);
    chk_bit(fn, s);
    @(posedge i_clk) live <= 1'h1;
  endtask : do_reset

  task automatic rnd(input int n);
    logic [31:0] r;
    repeat (n) begin
      @(posedge i_clk);
      r = $random(seed);
      {rd, sel, ext, isc, drv, gout, dir} <= r[12:0];
      dir_we <= (r[15:13] == 3'h0);
    end
  endtask : rnd

  // Hold is refused while the bus is busy, then acknowledged two edges after idle
  task automatic hold_run(input logic [3:0] n);
    @(posedge i_clk) idle <= 1'h0;
    len   <= n;
    start <= 1'h1;
    @(posedge i_clk) start <= 1'h0;
    repeat (4) @(posedge i_clk);
    #1 chk_bit(pin_o[2], 1'h1);
    @(posedge i_clk) idle <= 1'h1;
    @(posedge i_clk);
    #1 chk_bit(pin_o[2], 1'h1);
    @(posedge i_clk);
    #1 chk_bit(pin_o[2], 1'h0);
    chk_bit(bus_oe, 1'h0);
    repeat (n + 2) @(posedge i_clk);
    #1 chk_bit(pin_o[2], 1'h0);
    @(posedge i_clk);
    #1 chk_bit(pin_o[2], 1'h1);
    chk_bit(bus_oe, 1'h1);
  endtask : hold_run

  initial begin
    seed        = 11518;
    miscompares = 0;
    compares    = 0;
    {i_resetn, strap, dir_we, rd, idle, sel, ext, isc, start, live, mode} <= 11'h000;
    {dir, gout, drv} <= 9'h000;
    len <= 4'h0;
    do_reset(1'h1);
    rnd(200);
    hold_run(4'h0);
    hold_run(4'h3);
    hold_run(4'h7);
    rnd(100);
    chk_bit(fn, 1'h1);
    do_reset(1'h0);
    idle <= 1'h1;
    rnd(400);
    chk_bit(fn, 1'h0);
    summarize();
  end

  // About 800 cycles are needed; 10000 cycles, twelve and a half times that, ends a hang
  initial begin
    #100000;
    miscompares++;
    summarize();
  end
endmodule : sbh_pin_mux_tb
